// ---- src/pmac_pkg.sv ----
// Constants shared by the power monitor ADC configuration block
package pmac_pkg;
  // Register indices on the internal register port
  localparam logic [5:0] ADDR_SETUP  = 6'h01;
  localparam logic [5:0] ADDR_CAL    = 6'h02;
  localparam logic [5:0] ADDR_DRIFT  = 6'h03;
  localparam logic [5:0] ADDR_RESULT = 6'h04;
  // Reset values
  localparam logic [15:0] SETUP_RST = 16'hFB68;
  localparam logic [14:0] CAL_RST   = 15'h1000;
  localparam logic [13:0] DRIFT_RST = 14'h0000;
  // Field positions inside adc_setup, and the result position in the result register
  localparam int MODE_LSB     = 12;
  localparam int RAIL_CT_LSB  = 9;
  localparam int SENSE_CT_LSB = 6;
  localparam int THERM_CT_LSB = 3;
  localparam int MEAN_LSB     = 0;
  localparam int RESULT_LSB   = 4;
  // Conversion times in microseconds, per time code, and the clock rate in MHz
  localparam int T_US_0 = 50;
  localparam int T_US_1 = 84;
  localparam int T_US_2 = 150;
  localparam int T_US_3 = 280;
  localparam int T_US_4 = 540;
  localparam int T_US_5 = 1052;
  localparam int T_US_6 = 2074;
  localparam int T_US_7 = 4120;
  localparam int CLK_MHZ = 25;
  // Drift correction reference die temperature, degrees C
  localparam int REF_TEMP_C = 25;
  // Result LSB weight in picovolts, wide and narrow span
  localparam int LSB_PV_WIDE   = 312500;
  localparam int LSB_PV_NARROW = 78125;
  // Channel numbers
  localparam logic [1:0] CH_RAIL  = 2'b00;
  localparam logic [1:0] CH_SENSE = 2'b01;
  localparam logic [1:0] CH_THERM = 2'b10;
  // Averaging count per code, as log2 of the sample count
  localparam int MEAN_LOG2_0 = 0;
  localparam int MEAN_LOG2_1 = 2;
  localparam int MEAN_LOG2_2 = 4;
  localparam int MEAN_LOG2_3 = 6;
  localparam int MEAN_LOG2_4 = 7;
  localparam int MEAN_LOG2_5 = 8;
  localparam int MEAN_LOG2_6 = 9;
  localparam int MEAN_LOG2_7 = 10;
  localparam logic [1:0] CH_NONE  = 2'b11;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01
  } pmac_state_t;
endpackage

// ---- src/pmac_adc_config.sv ----
// ADC setup, sense calibration and sense voltage result registers
//
// Summary of operation
// - Mode field picks shutdown, triggered or continuous
// - Codes 1h-7h convert chosen channels once
// - Codes 9h-Fh repeat the same channel sets
// - Rail conversion time from eight-entry code table
// - Sense conversion time uses same table
// - Thermal conversion time uses same table
// - Mean count 1 to 1024 on all channels
// - Results update only after averaging completes
// - Fifteen-bit calibration constant, reset 1000h
// - Calibration constant sets current LSB size
// - Fourteen-bit drift coefficient, 1 ppm per LSB
// - Drift correction referenced to 25 degrees C
// - Sense result is 20-bit signed, bits 23-4
// - Result LSB 312.5 nV or 78.125 nV
// - Reserved bits read back as zero
// - Span select bit picks sense input range
// - Drift correction only while enable is set
`timescale 1ns/10ps
module pmac_adc_config #(
  parameter int CYC_PER_US = pmac_pkg::CLK_MHZ
) (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        clock_en,
  input  wire logic        soft_reset,
  input  wire logic [5:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_rd,
  output logic      [23:0] reg_rdata,
  input  wire logic        input_span_select,
  input  wire logic        drift_correction_enable,
  input  wire logic [19:0] adc_sample,
  output logic      [1:0]  adc_chan,
  output logic             adc_active,
  output logic             sample_take,
  output logic             result_update,
  output logic      [14:0] current_scale,
  output logic      [13:0] drift_coeff,
  output logic             span_narrow
);
  // Longest conversion fixes the tick counter width
  localparam int TICK_W = $clog2(pmac_pkg::T_US_7 * CYC_PER_US + 1);

  // Conversion time per code, in microseconds
  localparam int CT_US [8] = '{
    pmac_pkg::T_US_0,
    pmac_pkg::T_US_1,
    pmac_pkg::T_US_2,
    pmac_pkg::T_US_3,
    pmac_pkg::T_US_4,
    pmac_pkg::T_US_5,
    pmac_pkg::T_US_6,
    pmac_pkg::T_US_7
  };

  // Averaging count per code, as a power of two
  localparam int MEAN_SH [8] = '{
    pmac_pkg::MEAN_LOG2_0,
    pmac_pkg::MEAN_LOG2_1,
    pmac_pkg::MEAN_LOG2_2,
    pmac_pkg::MEAN_LOG2_3,
    pmac_pkg::MEAN_LOG2_4,
    pmac_pkg::MEAN_LOG2_5,
    pmac_pkg::MEAN_LOG2_6,
    pmac_pkg::MEAN_LOG2_7
  };

  default clocking cb_main @(posedge clock);
  endclocking

  default disable iff (!resetn);

  // Host visible registers
  logic        [15:0]       setup_r;
  logic        [15:0]       setup_nxt;
  logic        [14:0]       cal_r;
  logic        [14:0]       cal_nxt;
  logic        [13:0]       drift_r;
  logic        [13:0]       drift_nxt;
  logic        [19:0]       result_r;
  logic        [19:0]       result_nxt;
  logic                     start_r;

  // Conversion sequencer
  pmac_pkg::pmac_state_t    state_r;
  pmac_pkg::pmac_state_t    state_nxt;
  logic        [1:0]        chan_r;
  logic        [1:0]        chan_nxt;
  logic        [TICK_W-1:0] tick_r;
  logic        [TICK_W-1:0] tick_nxt;
  logic        [10:0]       taken_r;
  logic        [10:0]       taken_nxt;
  logic signed [29:0]       acc_r;
  logic signed [29:0]       acc_nxt;

  // Decode
  logic                     setup_wr;
  logic                     cal_wr;
  logic                     drift_wr;
  logic                     step;
  logic        [2:0]        chan_mask;
  logic                     run_cont;
  logic        [1:0]        first_chan;
  logic        [1:0]        next_chan;
  logic                     chan_on;
  logic                     conv_busy;
  logic        [2:0]        conv_code;
  logic        [TICK_W-1:0] conv_len;
  logic                     last_tick;
  logic        [2:0]        mean_code;
  logic        [3:0]        mean_shift;
  logic        [10:0]       mean_len;
  logic                     last_sample;
  logic                     chan_done;
  logic                     seq_end;
  logic signed [29:0]       sample_ext;
  logic signed [29:0]       acc_sum;
  logic        [19:0]       mean_val;
  logic        [23:0]       rd_mux;

  // Register writes; the result register ignores writes
  assign setup_wr  = reg_wr && (reg_addr == pmac_pkg::ADDR_SETUP);
  assign cal_wr    = reg_wr && (reg_addr == pmac_pkg::ADDR_CAL);
  assign drift_wr  = reg_wr && (reg_addr == pmac_pkg::ADDR_DRIFT);
  assign step      = clock_en && !soft_reset;

  assign setup_nxt = setup_wr ? reg_wdata : setup_r;
  assign cal_nxt   = cal_wr ? reg_wdata[14:0] : cal_r;
  assign drift_nxt = drift_wr ? reg_wdata[13:0] : drift_r;

  // Mode field: low three bits pick channels, top bit repeats
  assign chan_mask = setup_r[pmac_pkg::MODE_LSB +: 3];
  assign run_cont  = setup_r[pmac_pkg::MODE_LSB + 3];

  // Empty channel set is shutdown, whatever the top bit
  assign first_chan = chan_mask[0] ? pmac_pkg::CH_RAIL
                    : chan_mask[1] ? pmac_pkg::CH_SENSE
                    : chan_mask[2] ? pmac_pkg::CH_THERM
                    : pmac_pkg::CH_NONE;

  assign next_chan = (chan_r == pmac_pkg::CH_RAIL && chan_mask[1])
                   ? pmac_pkg::CH_SENSE
                   : (chan_r != pmac_pkg::CH_THERM && chan_mask[2])
                   ? pmac_pkg::CH_THERM
                   : pmac_pkg::CH_NONE;

  assign chan_on = (chan_r == pmac_pkg::CH_RAIL  && chan_mask[0])
                || (chan_r == pmac_pkg::CH_SENSE && chan_mask[1])
                || (chan_r == pmac_pkg::CH_THERM && chan_mask[2]);

  assign conv_busy = (state_r == pmac_pkg::ST_CONV);

  // Per-channel conversion time code
  assign conv_code = (chan_r == pmac_pkg::CH_RAIL)
                   ? setup_r[pmac_pkg::RAIL_CT_LSB +: 3]
                   : (chan_r == pmac_pkg::CH_SENSE)
                   ? setup_r[pmac_pkg::SENSE_CT_LSB +: 3]
                   : setup_r[pmac_pkg::THERM_CT_LSB +: 3];
  assign conv_len  = TICK_W'(CT_US[conv_code] * CYC_PER_US);
  // Compare with >= so a shrunken field cannot run the counter away
  assign last_tick = conv_busy && (tick_r >= conv_len - TICK_W'(1));

  // Same averaging count for every active channel
  assign mean_code   = setup_r[pmac_pkg::MEAN_LSB +: 3];
  assign mean_shift  = 4'(MEAN_SH[mean_code]);
  assign mean_len    = 11'(11'h001 << mean_shift);
  assign last_sample = last_tick && (taken_r >= mean_len - 11'h001);
  // A fresh mode write wins over a finishing channel
  assign chan_done   = last_sample && !start_r;
  assign seq_end     = chan_done && (next_chan == pmac_pkg::CH_NONE)
                    && !run_cont;

  assign sample_ext = {{10{adc_sample[19]}}, adc_sample};
  assign acc_sum    = acc_r + sample_ext;
  assign mean_val   = 20'(acc_sum >>> mean_shift);

  assign state_nxt = start_r
                   ? ((first_chan != pmac_pkg::CH_NONE) ? pmac_pkg::ST_CONV
                                                         : pmac_pkg::ST_IDLE)
                   : seq_end ? pmac_pkg::ST_IDLE : state_r;

  assign chan_nxt = start_r ? first_chan
                  : !chan_done ? chan_r
                  : (next_chan != pmac_pkg::CH_NONE) ? next_chan
                  : run_cont ? first_chan : pmac_pkg::CH_NONE;

  assign tick_nxt = (start_r || last_tick || !conv_busy) ? {TICK_W{1'b0}}
                  : tick_r + TICK_W'(1);

  assign taken_nxt = (start_r || last_sample) ? 11'h000
                   : last_tick ? taken_r + 11'h001 : taken_r;

  assign acc_nxt = (start_r || last_sample) ? 30'h00000000
                 : last_tick ? acc_sum : acc_r;

  // Result moves only once the whole mean is complete
  assign result_nxt = (chan_done && chan_r == pmac_pkg::CH_SENSE)
                    ? mean_val : result_r;

  // Reserved bits are padded with zero
  assign rd_mux = (reg_addr == pmac_pkg::ADDR_SETUP)  ? {8'h00, setup_r}
                : (reg_addr == pmac_pkg::ADDR_CAL)    ? {9'h000, cal_r}
                : (reg_addr == pmac_pkg::ADDR_DRIFT)  ? {10'h000, drift_r}
                : (reg_addr == pmac_pkg::ADDR_RESULT) ? {result_r, 4'h0}
                : 24'h000000;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      setup_r <= pmac_pkg::SETUP_RST;
      cal_r   <= pmac_pkg::CAL_RST;
      drift_r <= pmac_pkg::DRIFT_RST;
      start_r <= 1'h1;
    end else if (clock_en) begin
      if (soft_reset) begin
        setup_r <= pmac_pkg::SETUP_RST;
        cal_r   <= pmac_pkg::CAL_RST;
        drift_r <= pmac_pkg::DRIFT_RST;
        start_r <= 1'h1;
      end else begin
        setup_r <= setup_nxt;
        cal_r   <= cal_nxt;
        drift_r <= drift_nxt;
        start_r <= setup_wr;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_r  <= pmac_pkg::ST_IDLE;
      chan_r   <= pmac_pkg::CH_NONE;
      tick_r   <= {TICK_W{1'b0}};
      taken_r  <= 11'h000;
      acc_r    <= 30'h00000000;
      result_r <= 20'h00000;
    end else if (clock_en) begin
      if (soft_reset) begin
        state_r  <= pmac_pkg::ST_IDLE;
        chan_r   <= pmac_pkg::CH_NONE;
        tick_r   <= {TICK_W{1'b0}};
        taken_r  <= 11'h000;
        acc_r    <= 30'h00000000;
        result_r <= 20'h00000;
      end else begin
        state_r  <= state_nxt;
        chan_r   <= chan_nxt;
        tick_r   <= tick_nxt;
        taken_r  <= taken_nxt;
        acc_r    <= acc_nxt;
        result_r <= result_nxt;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      reg_rdata     <= 24'h000000;
      adc_chan      <= pmac_pkg::CH_NONE;
      adc_active    <= 1'h0;
      sample_take   <= 1'h0;
      result_update <= 1'h0;
      current_scale <= pmac_pkg::CAL_RST;
      drift_coeff   <= 14'h0000;
      span_narrow   <= 1'h0;
    end else if (clock_en) begin
      if (reg_rd) begin
        reg_rdata <= rd_mux;
      end
      adc_chan      <= chan_r;
      adc_active    <= conv_busy;
      sample_take   <= last_tick && !start_r;
      result_update <= chan_done;
      current_scale <= cal_r;
      // Coefficient is applied about 25 C by the correction stage
      drift_coeff   <= drift_correction_enable ? drift_r : 14'h0000;
      span_narrow   <= input_span_select;
    end
  end

  property p_shutdown;
    (step && start_r && chan_mask == 3'h0) |=> (state_r == pmac_pkg::ST_IDLE);
  endproperty
  a_shutdown: assert property (p_shutdown)
    else $error("shutdown code started a conversion");

  property p_trig_once;
    (step && seq_end) |=> (state_r == pmac_pkg::ST_IDLE);
  endproperty
  a_trig_once: assert property (p_trig_once)
    else $error("single shot sequence did not stop");

  property p_cont_repeat;
    (step && chan_done && run_cont) |=> (state_r == pmac_pkg::ST_CONV);
  endproperty
  a_cont_repeat: assert property (p_cont_repeat)
    else $error("continuous mode stopped converting");

  property p_chan_sel;
    (conv_busy && !start_r) |-> chan_on;
  endproperty
  a_chan_sel: assert property (p_chan_sel)
    else $error("converting a channel the mode did not select");

  property p_update_end;
    result_update |-> $past(chan_done);
  endproperty
  a_update_end: assert property (p_update_end)
    else $error("result update before averaging finished");

  property p_tick_range;
    (conv_busy && !start_r) |-> (tick_r < conv_len);
  endproperty
  a_tick_range: assert property (p_tick_range)
    else $error("conversion ran past its time");

  property p_rsvd_zero;
    (clock_en && reg_rd && reg_addr == pmac_pkg::ADDR_RESULT)
      |=> (reg_rdata[3:0] == 4'h0);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("result low bits not zero");

  property p_span;
    clock_en |=> (span_narrow == $past(input_span_select));
  endproperty
  a_span: assert property (p_span)
    else $error("span select not passed on");

  c_trig_done: cover property (seq_end);
  c_cont_wrap: cover property (chan_done && run_cont);
  c_sense_mean: cover property (chan_done && chan_r == pmac_pkg::CH_SENSE
                                && mean_code != 3'h0);
  c_shutdown: cover property (start_r && chan_mask == 3'h0);
endmodule

// ---- dv/pmac_sample_src.sv ----
// Sample source on the converter side
`timescale 1ns/10ps
// Alternates two signed samples, one step per sample taken
module pmac_sample_src #(
  parameter logic [19:0] FIRST_VAL  = 20'hFFF38,
  parameter logic [19:0] SECOND_VAL = 20'hFFFCE
) (
  input  wire logic        clock,
  input  wire logic        sample_take,
  output logic      [19:0] adc_sample
);
  logic phase_r = 1'h0;
  always @(negedge clock) begin
    if (sample_take) begin
      phase_r <= ~phase_r;
    end
  end
  assign adc_sample = phase_r ? SECOND_VAL : FIRST_VAL;
endmodule

// ---- dv/pmac_adc_config_test.sv ----
// Register bench for the ADC setup block
`timescale 1ns/10ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin error_cnt++; \
  $display("mismatch %0t %h %h", $time, (a), (e)); end end
module pmac_adc_config_test;
  logic        clock         = 1'h0;
  logic        resetn        = 1'h0;
  logic        soft_rst      = 1'h0;
  logic [5:0]  reg_addr      = 6'h00;
  logic        reg_wr        = 1'h0;
  logic [15:0] reg_wdata     = 16'h0000;
  logic        reg_rd        = 1'h0;
  logic        span_sel      = 1'h0;
  logic        drift_en      = 1'h0;
  logic [23:0] reg_rdata;
  logic [23:0] q;
  logic [19:0] adc_sample;
  logic [1:0]  adc_chan;
  logic        adc_active;
  logic        sample_take;
  logic        result_update;
  logic [14:0] current_scale;
  logic [13:0] drift_coeff;
  logic        span_narrow;
  int          error_cnt     = 0;
  int          tests_run     = 0;
  int          update_cnt    = 0;
  int          upd_base      = 0;

  initial begin
    forever #20 clock = ~clock;
  end

  pmac_sample_src src_u (
    .clock       (clock),
    .sample_take (sample_take),
    .adc_sample  (adc_sample)
  );

  pmac_adc_config dut_u (
    .clock                   (clock),
    .resetn                  (resetn),
    .clock_en                (1'h1),
    .soft_reset              (soft_rst),
    .reg_addr                (reg_addr),
    .reg_wr                  (reg_wr),
    .reg_wdata               (reg_wdata),
    .reg_rd                  (reg_rd),
    .reg_rdata               (reg_rdata),
    .input_span_select       (span_sel),
    .drift_correction_enable (drift_en),
    .adc_sample              (adc_sample),
    .adc_chan                (adc_chan),
    .adc_active              (adc_active),
    .sample_take             (sample_take),
    .result_update           (result_update),
    .current_scale           (current_scale),
    .drift_coeff             (drift_coeff),
    .span_narrow             (span_narrow)
  );

  // Counted away from the edge that launches the pulse
  always @(negedge clock) begin
    if (result_update === 1'h1) begin
      update_cnt++;
    end
  end

  task automatic wr_reg(input logic [5:0] a, input logic [15:0] d);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'h1;
    reg_rd    = 1'h0;
    @(negedge clock);
  endtask

  task automatic rd_reg(input logic [5:0] a, output logic [23:0] v);
    reg_addr = a;
    reg_wr   = 1'h0;
    reg_rd   = 1'h1;
    @(negedge clock);
    v = reg_rdata;
  endtask

  task automatic idle(input int n);
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    repeat (n) @(negedge clock);
  endtask

  task automatic end_of_test();
    $display("counts: %0d compares %0d mismatches", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(negedge clock);
    resetn = 1'h1;
    rd_reg(pmac_pkg::ADDR_SETUP, q);
    `CHK(q, 24'h00FB68)
    rd_reg(pmac_pkg::ADDR_CAL, q);
    `CHK(q, 24'h001000)
    rd_reg(pmac_pkg::ADDR_DRIFT, q);
    `CHK(q, 24'h000000)
    rd_reg(pmac_pkg::ADDR_RESULT, q);
    `CHK(q, 24'h000000)
    $display("test defaults done");
    wr_reg(pmac_pkg::ADDR_CAL, 16'hFFFF);
    rd_reg(pmac_pkg::ADDR_CAL, q);
    `CHK(q, 24'h007FFF)
    `CHK(current_scale, 15'h7FFF)
    wr_reg(pmac_pkg::ADDR_DRIFT, 16'hFFFF);
    rd_reg(pmac_pkg::ADDR_DRIFT, q);
    `CHK(q, 24'h003FFF)
    `CHK(drift_coeff, 14'h0000)
    drift_en = 1'h1;
    span_sel = 1'h1;
    idle(2);
    `CHK(drift_coeff, 14'h3FFF)
    `CHK(span_narrow, 1'h1)
    $display("test writes done");
    upd_base = update_cnt;
    wr_reg(pmac_pkg::ADDR_SETUP, 16'h2000);
    idle(10);
    `CHK(adc_active, 1'h1)
    `CHK(adc_chan, 2'h1)
    idle(1300);
    `CHK(adc_active, 1'h0)
    `CHK(update_cnt - upd_base, 1)
    rd_reg(pmac_pkg::ADDR_RESULT, q);
    `CHK(q, 24'hFFF380)
    $display("test single shot done");
    upd_base = update_cnt;
    wr_reg(pmac_pkg::ADDR_SETUP, 16'hA001);
    idle(2600);
    `CHK(update_cnt - upd_base, 0)
    `CHK(adc_active, 1'h1)
    idle(2600);
    `CHK(update_cnt - upd_base, 1)
    rd_reg(pmac_pkg::ADDR_RESULT, q);
    `CHK(q, 24'hFFF830)
    $display("test averaging done");
    wr_reg(pmac_pkg::ADDR_SETUP, 16'h8000);
    idle(3);
    `CHK(adc_active, 1'h0)
    soft_rst = 1'h1;
    idle(1);
    soft_rst = 1'h0;
    rd_reg(pmac_pkg::ADDR_SETUP, q);
    `CHK(q, 24'h00FB68)
    $display("test shutdown and soft reset done");
    end_of_test();
  end

  // Tests need about 6500 cycles; this allows 10000
  initial begin
    #400000;
    error_cnt++;
    end_of_test();
  end
endmodule
